// ---- logic/uart_control_config.sv ----
// Summary of operation
// - Global off floats both pins
// - Off empties buffer, resets baud counter
// - Off clears transmit/receive enables and flags, sets idles
// - Off aborts transfers; config kept for re-enable
// - Word select picks 8 or 9 bits
// - Parity enable and even/odd select
// - Break after buffer drains, 13+ bits low
// - Ninth bit: receive read-only, transmit write-only
// - Transmit disable aborts, resets, floats pin
// - Receive disable aborts, resets; floats no pin (single wire: transmitter takes shared pin)
// - Fast select switches baud generator mode
// - Address bit set gives address and request
// - Address bit clear discards word silently
// - Wake on falling edge while clock off
// - No wake while clock runs or disabled
// - Receive interrupt from full or overrun
// - Idle interrupt from transmitter idle flag
// - Empty interrupt from transmit empty flag
// - Single wire selects shared pin role
// - Both enabled: shared pin only receives
// - Single wire upper bits read zero
// - Baud = clock / (64 or 16 times N+1)
// - NRZ, one start bit, LSB first
// - Receiver checks one stop bit only
`timescale 1ns/1ps
`include "uart_ctrl_defs.svh"

module uart_control_config (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic [7:0] rd_data_o,
    input wire logic uart_clk_off_i,
    output logic tx_o,
    output logic tx_oe_o,
    input wire logic shared_i,
    output logic shared_o,
    output logic shared_oe_o,
    output logic irq_o
);
    import uart_ctrl_pkg::*;

    // ---------------------------------------------
    // Control and status state
    // ---------------------------------------------
    logic global_on_q, word9_q, par_on_q, par_odd_q, stop2_q;
    logic send_break_q, rx_ninth_q, tx_ninth_q;
    logic tx_on_q, rx_on_q, fast_q, addr_on_q, wake_on_q;
    logic rx_irq_on_q, idle_irq_on_q, empty_irq_on_q, one_wire_q;
    logic [7:0] baud_div_q, tx_buf_q, rx_buf_q;
    logic tx_empty_q, tx_idle_q, rx_full_q, overrun_q;
    logic framing_err_flag_q, parity_err_flag_q, noise_q, armed_q, wake_q;
    tx_state_e tx_st_q;
    rx_state_e rx_st_q;
    logic [11:0] tx_sh_q;
    logic [3:0] tx_os_q, tx_bits_q, rx_os_q, rx_idx_q;
    logic [8:0] rx_sh_q;
    logic [2:0] vote_q;
    logic rx_noisy_q, rx_prev_q, tx_line_q;
    logic os_tick;
    logic [1:0] sync;
    logic tx_act, rx_act, wr_frame, wr_data, rd_data, rd_status;
    logic rx_in, clk_off, maj, noisy, rx_done, rx_store, rx_fall;
    logic [3:0] rx_last;
    logic [8:0] rx_word, tx_word;
    logic addr_bit, par_bad, shared_tx, tx_load;

    assign tx_act = global_on_q && tx_on_q;
    assign rx_act = global_on_q && rx_on_q;
    assign wr_frame = wr_en_i && addr_i == `REG_FRAME;
    assign wr_data = wr_en_i && addr_i == `REG_DATA;
    assign rd_data = rd_en_i && addr_i == `REG_DATA;
    assign rd_status = rd_en_i && addr_i == `REG_STATUS;
    assign rx_in = sync[0];
    assign clk_off = sync[1];

    // ---------------------------------------------
    // Pin synchroniser and baud generator
    // ---------------------------------------------
    uart_pin_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i({uart_clk_off_i, shared_i}),
        .sync_o(sync)
    );

    uart_baud_gen u_baud (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(global_on_q),
        .fast_i(fast_q),
        .div_i(baud_div_q),
        .tick_o(os_tick)
    );

    // ---------------------------------------------
    // Configuration registers
    // ---------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            global_on_q <= 1'b0;
            word9_q <= 1'b0;
            par_on_q <= 1'b0;
            par_odd_q <= 1'b0;
            stop2_q <= 1'b0;
            tx_ninth_q <= 1'b0;
            fast_q <= 1'b0;
            addr_on_q <= 1'b0;
            wake_on_q <= 1'b0;
            rx_irq_on_q <= 1'b0;
            idle_irq_on_q <= 1'b0;
            empty_irq_on_q <= 1'b0;
            one_wire_q <= 1'b0;
            baud_div_q <= 8'h00;
        end else if (wr_frame) begin
            global_on_q <= wr_data_i[`FR_ON];
            word9_q <= wr_data_i[`FR_WORD9];
            par_on_q <= wr_data_i[`FR_PAR_ON];
            par_odd_q <= wr_data_i[`FR_PAR_ODD];
            stop2_q <= wr_data_i[`FR_STOP2];
            tx_ninth_q <= wr_data_i[`FR_TX9];
        end else if (wr_en_i && addr_i == `REG_ENABLE) begin
            fast_q <= wr_data_i[`EN_FAST];
            addr_on_q <= wr_data_i[`EN_ADDR];
            wake_on_q <= wr_data_i[`EN_WAKE];
            rx_irq_on_q <= wr_data_i[`EN_RX_IRQ];
            idle_irq_on_q <= wr_data_i[`EN_IDLE_IRQ];
            empty_irq_on_q <= wr_data_i[`EN_EMPTY_IRQ];
        end else if (wr_en_i && addr_i == `REG_WIRE) begin
            one_wire_q <= wr_data_i[`SW_SEL];
        end else if (wr_en_i && addr_i == `REG_BAUD) begin
            baud_div_q <= wr_data_i;
        end
    end

    // Enables that the global switch clears
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            tx_on_q <= 1'b0;
            rx_on_q <= 1'b0;
            send_break_q <= 1'b0;
        end else if (!global_on_q) begin
            tx_on_q <= 1'b0;
            rx_on_q <= 1'b0;
            send_break_q <= 1'b0;
            if (wr_frame) begin
                send_break_q <= wr_data_i[`FR_BREAK];
            end
        end else begin
            if (wr_en_i && addr_i == `REG_ENABLE) begin
                tx_on_q <= wr_data_i[`EN_TX];
                rx_on_q <= wr_data_i[`EN_RX];
            end
            if (wr_frame) begin
                send_break_q <= wr_data_i[`FR_BREAK];
            end
        end
    end

    // ---------------------------------------------
    // Transmitter
    // ---------------------------------------------
    always_comb begin
        tx_word = {word9_q ? tx_ninth_q : 1'b1, tx_buf_q};
        if (par_on_q && word9_q) begin
            tx_word[8] = ^tx_buf_q ^ par_odd_q;
        end else if (par_on_q) begin
            tx_word[7] = ^tx_buf_q[6:0] ^ par_odd_q;
        end
    end

    assign tx_load = tx_act && tx_st_q == TX_IDLE && !tx_empty_q;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || !tx_act) begin
            tx_st_q <= TX_IDLE;
            tx_sh_q <= 12'hfff;
            tx_os_q <= 4'h0;
            tx_bits_q <= 4'h0;
            tx_line_q <= 1'b1;
        end else begin
            case (tx_st_q)
                TX_IDLE: begin
                    tx_os_q <= 4'h0;
                    tx_bits_q <= 4'h0;
                    tx_line_q <= 1'b1;
                    if (tx_load) begin
                        tx_sh_q <= {2'b11, tx_word, 1'b0};
                        tx_st_q <= TX_SHIFT;
                        tx_line_q <= 1'b0;
                    end else if (send_break_q) begin
                        tx_st_q <= TX_BREAK;
                        tx_line_q <= 1'b0;
                    end
                end
                TX_SHIFT: begin
                    if (os_tick) begin
                        tx_os_q <= tx_os_q + 4'h1;
                        if (tx_os_q == `OS_LAST) begin
                            tx_sh_q <= {1'b1, tx_sh_q[11:1]};
                            tx_line_q <= tx_sh_q[1];
                            tx_bits_q <= tx_bits_q + 4'h1;
                            if (tx_bits_q == `BASE_BITS - 4'h1 + {3'h0, word9_q} + {3'h0, stop2_q}) begin
                                tx_st_q <= TX_IDLE;
                                tx_line_q <= 1'b1;
                            end
                        end
                    end
                end
                TX_BREAK: begin
                    tx_line_q <= 1'b0;
                    if (os_tick) begin
                        tx_os_q <= tx_os_q + 4'h1;
                        if (tx_os_q == `OS_LAST && tx_bits_q != `BREAK_BITS) begin
                            tx_bits_q <= tx_bits_q + 4'h1;
                        end
                    end
                    if (tx_bits_q == `BREAK_BITS && !send_break_q) begin
                        tx_st_q <= TX_IDLE;
                        tx_line_q <= 1'b1;
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    // ---------------------------------------------
    // Receiver
    // ---------------------------------------------
    assign maj = (vote_q[0] & vote_q[1]) | (vote_q[0] & vote_q[2]) | (vote_q[1] & vote_q[2]);
    assign noisy = !(&vote_q) && |vote_q;
    assign rx_last = `BASE_BITS - 4'h1 + {3'h0, word9_q};
    assign rx_done = rx_st_q == RX_FRAME && os_tick && rx_os_q == `OS_LAST;
    assign rx_word = word9_q ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
    assign addr_bit = word9_q ? rx_word[8] : rx_word[7];
    assign par_bad = par_on_q && ((word9_q ? ^rx_word : ^rx_word[7:0]) ^ par_odd_q);
    assign rx_store = rx_done && rx_idx_q == rx_last && (!addr_on_q || addr_bit);
    assign rx_fall = rx_prev_q && !rx_in;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || !rx_act) begin
            rx_st_q <= RX_IDLE;
            rx_os_q <= 4'h0;
            rx_idx_q <= 4'h0;
            rx_sh_q <= 9'h000;
            vote_q <= 3'h7;
            rx_noisy_q <= 1'b0;
            rx_prev_q <= 1'b1;
        end else begin
            rx_prev_q <= rx_in;
            case (rx_st_q)
                RX_IDLE: begin
                    rx_os_q <= 4'h0;
                    rx_idx_q <= 4'h0;
                    rx_noisy_q <= 1'b0;
                    if (rx_fall) begin
                        rx_st_q <= RX_FRAME;
                    end
                end
                RX_FRAME: begin
                    if (os_tick) begin
                        rx_os_q <= rx_os_q + 4'h1;
                        if (rx_os_q == `OS_VOTE_A || rx_os_q == `OS_VOTE_B || rx_os_q == `OS_VOTE_C) begin
                            vote_q <= {vote_q[1:0], rx_in};
                        end
                        if (rx_os_q == `OS_LAST) begin
                            rx_idx_q <= rx_idx_q + 4'h1;
                            rx_noisy_q <= rx_noisy_q | noisy;
                            if (rx_idx_q == 4'h0 && maj) begin
                                rx_st_q <= RX_IDLE;
                            end else if (rx_idx_q == rx_last) begin
                                rx_st_q <= RX_IDLE;
                            end else if (rx_idx_q != 4'h0) begin
                                rx_sh_q <= {maj, rx_sh_q[8:1]};
                            end
                        end
                    end
                end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end

    // ---------------------------------------------
    // Data buffers and status flags
    // ---------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            tx_buf_q <= 8'h00;
            rx_buf_q <= 8'h00;
            rx_ninth_q <= 1'b0;
        end else begin
            if (wr_data) begin
                tx_buf_q <= wr_data_i;
            end
            if (rx_store && !rx_full_q) begin
                rx_buf_q <= rx_word[7:0];
                rx_ninth_q <= rx_word[8];
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || !global_on_q) begin
            tx_empty_q <= 1'b1;
            tx_idle_q <= 1'b1;
            rx_full_q <= 1'b0;
            overrun_q <= 1'b0;
            framing_err_flag_q <= 1'b0;
            parity_err_flag_q <= 1'b0;
            noise_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            if (rd_status) begin
                armed_q <= 1'b1;
            end else if (rd_data || wr_data) begin
                armed_q <= 1'b0;
            end
            // Clears first, so a same-cycle event wins
            if (rd_data && armed_q) begin
                rx_full_q <= 1'b0;
                overrun_q <= 1'b0;
                framing_err_flag_q <= 1'b0;
                parity_err_flag_q <= 1'b0;
                noise_q <= 1'b0;
            end
            if (rx_store && rx_full_q) begin
                overrun_q <= 1'b1;
            end else if (rx_store) begin
                rx_full_q <= 1'b1;
                framing_err_flag_q <= !maj;
                parity_err_flag_q <= par_bad;
                noise_q <= rx_noisy_q | noisy;
            end
            if (!tx_on_q) begin
                tx_empty_q <= 1'b1;
            end else if (tx_load) begin
                tx_empty_q <= 1'b1;
            end else if (wr_data) begin
                tx_empty_q <= 1'b0;
            end
            if (wr_data) begin
                tx_idle_q <= 1'b0;
            end else if (tx_empty_q && tx_st_q == TX_IDLE && !tx_load && !send_break_q) begin
                tx_idle_q <= 1'b1;
            end else if (tx_st_q != TX_IDLE) begin
                tx_idle_q <= 1'b0;
            end
        end
    end

    // Wake request only while the clock is off
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= (wake_q && clk_off) || (wake_on_q && clk_off && rx_fall);
        end
    end

    // ---------------------------------------------
    // Pins and interrupt request
    // ---------------------------------------------
    assign shared_tx = one_wire_q && tx_act && !rx_on_q;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            tx_o <= 1'b1;
            tx_oe_o <= 1'b0;
            shared_o <= 1'b1;
            shared_oe_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            tx_o <= tx_line_q;
            tx_oe_o <= tx_act && !shared_tx;
            shared_o <= tx_line_q;
            shared_oe_o <= shared_tx;
            irq_o <= (rx_irq_on_q && (rx_full_q || overrun_q))
                || (idle_irq_on_q && tx_idle_q)
                || (empty_irq_on_q && tx_empty_q)
                || wake_q;
        end
    end

    // ---------------------------------------------
    // Register read port
    // ---------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || !rd_en_i) begin
            rd_data_o <= 8'h00;
        end else if (addr_i == `REG_FRAME) begin
            // Transmit ninth bit is write-only
            rd_data_o <= {global_on_q, word9_q, par_on_q, par_odd_q,
                          stop2_q, send_break_q, rx_ninth_q, 1'b0};
        end else if (addr_i == `REG_ENABLE) begin
            rd_data_o <= {tx_on_q, rx_on_q, fast_q, addr_on_q,
                          wake_on_q, rx_irq_on_q, idle_irq_on_q, empty_irq_on_q};
        end else if (addr_i == `REG_WIRE) begin
            rd_data_o <= {7'h00, one_wire_q};
        end else if (addr_i == `REG_STATUS) begin
            rd_data_o <= {parity_err_flag_q, noise_q, framing_err_flag_q, overrun_q,
                          rx_st_q == RX_IDLE, rx_full_q, tx_idle_q, tx_empty_q};
        end else if (addr_i == `REG_DATA) begin
            rd_data_o <= rx_buf_q;
        end else if (addr_i == `REG_BAUD) begin
            rd_data_o <= baud_div_q;
        end else begin
            rd_data_o <= 8'h00;
        end
    end

endmodule : uart_control_config

// ---- include/uart_ctrl_defs.svh ----
`ifndef UART_CTRL_DEFS_SVH
`define UART_CTRL_DEFS_SVH

// Register offsets
`define REG_FRAME 3'h0
`define REG_ENABLE 3'h1
`define REG_WIRE 3'h2
`define REG_STATUS 3'h3
`define REG_DATA 3'h4
`define REG_BAUD 3'h5

// Frame control fields
`define FR_ON 7
`define FR_WORD9 6
`define FR_PAR_ON 5
`define FR_PAR_ODD 4
`define FR_STOP2 3
`define FR_BREAK 2
`define FR_RX9 1
`define FR_TX9 0

// Enable and interrupt control fields
`define EN_TX 7
`define EN_RX 6
`define EN_FAST 5
`define EN_ADDR 4
`define EN_WAKE 3
`define EN_RX_IRQ 2
`define EN_IDLE_IRQ 1
`define EN_EMPTY_IRQ 0

// Single wire control field
`define SW_SEL 0

// Oversampling and framing counts
`define OS_LAST 4'hf
`define OS_VOTE_A 4'h7
`define OS_VOTE_B 4'h8
`define OS_VOTE_C 4'h9
`define SLOW_PRE_LAST 2'h3
`define BASE_BITS 4'ha
`define BREAK_BITS 4'hd

`endif

// ---- include/uart_ctrl_pkg.sv ----
package uart_ctrl_pkg;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SHIFT = 2'b01,
        TX_BREAK = 2'b10
    } tx_state_e;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_FRAME = 2'b01
    } rx_state_e;

endpackage : uart_ctrl_pkg

// ---- logic/uart_pin_sync.sv ----
`timescale 1ns/1ps

module uart_pin_sync (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [1:0] async_i,
    output logic [1:0] sync_o
);

    logic [1:0] meta_q;

    // ---------------------------------------------
    // Two-stage synchroniser per input
    // ---------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_sync
            always_ff @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    meta_q[g] <= 1'b1;
                    sync_o[g] <= 1'b1;
                end else begin
                    meta_q[g] <= async_i[g];
                    sync_o[g] <= meta_q[g];
                end
            end
        end
    endgenerate

endmodule : uart_pin_sync

// ---- logic/uart_baud_gen.sv ----
`timescale 1ns/1ps
`include "uart_ctrl_defs.svh"

module uart_baud_gen (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic run_i,
    input wire logic fast_i,
    input wire logic [7:0] div_i,
    output logic tick_o
);

    logic [7:0] cnt_q;
    logic [1:0] pre_q;

    // ---------------------------------------------
    // Oversample tick: 16 per bit
    // ---------------------------------------------
    // Fast: one tick per N+1 clocks; slow: per 4*(N+1)
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || !run_i) begin
            cnt_q <= 8'h00;
            pre_q <= 2'h0;
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (cnt_q == div_i) begin
                cnt_q <= 8'h00;
                pre_q <= pre_q + 2'h1;
                if (fast_i || pre_q == `SLOW_PRE_LAST) begin
                    tick_o <= 1'b1;
                    pre_q <= 2'h0;
                end
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

endmodule : uart_baud_gen

// ---- tb/uart_remote_model.sv ----
`timescale 1ns/1ps

module uart_remote_model #(
    parameter int BIT_CYC = 16
) (
    input wire logic sys_clk_i,
    input wire logic line_i,
    output logic drive_o,
    output logic oe_o,
    output logic [7:0] got_o
);
    // ----------------------------------------
    // Remote frame sender and catcher
    // ----------------------------------------
    initial begin
        drive_o = 1'b1;
        oe_o = 1'b0;
        got_o = 8'h00;
    end

    // Start, eight data bits LSB first, single stop, then release to the pull-up
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk_i);
            drive_o <= f[i];
            oe_o <= 1'b1;
            repeat (BIT_CYC - 1) @(posedge sys_clk_i);
        end
        @(posedge sys_clk_i);
        oe_o <= 1'b0;
    endtask : send

    // Samples each bit in its middle
    always begin : catch_frame
        logic [7:0] sh;
        @(negedge line_i);
        repeat (BIT_CYC / 2) @(posedge sys_clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge sys_clk_i);
            sh[i] = line_i;
        end
        got_o <= sh;
        repeat (BIT_CYC) @(posedge sys_clk_i);
    end
endmodule : uart_remote_model

// ---- tb/uart_control_config_chk.sv ----
`timescale 1ns/1ps

module uart_control_config_chk (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [7:0] rd_data_o,
    input wire logic tx_o,
    input wire logic tx_oe_o,
    input wire logic shared_oe_o,
    input wire logic irq_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    // Length of the current low stretch on the transmit pin
    logic [7:0] low_run_q;
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || tx_o)
            low_run_q <= 8'h00;
        else if (low_run_q != 8'hff)
            low_run_q <= low_run_q + 8'h01;
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    AST_WIRE_ZERO: assert property (rd_en_i && addr_i == 3'h2 |=> rd_data_o[7:1] == 7'h00)
        else $error("upper single wire bits read nonzero");
    AST_OFF_FLOAT: assert property (wr_en_i && addr_i == 3'h0 && !wr_data_i[7] |-> ##3 !tx_oe_o && !shared_oe_o)
        else $error("pins still driven after global off");
    AST_TX_ABORT: assert property (wr_en_i && addr_i == 3'h1 && !wr_data_i[7] |-> ##3 !tx_oe_o)
        else $error("transmit pin driven after transmit off");
    AST_BOTH_RX: assert property (wr_en_i && addr_i == 3'h1 && wr_data_i[7] && wr_data_i[6] |-> ##3 !shared_oe_o)
        else $error("shared pin driven with both directions on");
    AST_ONE_DRIVER: assert property (shared_oe_o |-> !tx_oe_o)
        else $error("shared pin and transmit pin driven together");
    AST_IDLE_HIGH: assert property ($rose(tx_oe_o) |-> tx_o)
        else $error("transmit pin not idle high when taken over");
    AST_BIT_MIN: assert property ($rose(tx_o) && tx_oe_o && $past(tx_oe_o) |-> low_run_q >= 8'h0f)
        else $error("low stretch on transmit pin shorter than one bit");
    AST_IRQ_QUIET: assert property (wr_en_i && addr_i == 3'h1 && wr_data_i[3:0] == 4'h0 |-> ##3 !irq_o)
        else $error("request raised with every source masked");
    AST_OFF_STATUS: assert property (wr_en_i && addr_i == 3'h0 && !wr_data_i[7] ##1
        (!wr_en_i throughout (##[0:5] (rd_en_i && addr_i == 3'h3))) |=> rd_data_o == 8'h0b)
        else $error("status after global off not idle and empty");

    cover property ($fell(tx_o) && tx_oe_o);
    cover property (rd_en_i && addr_i == 3'h3 ##1 rd_data_o[2]);
    cover property ($rose(irq_o));
endmodule : uart_control_config_chk

bind uart_control_config uart_control_config_chk i_chk (.sys_clk_i, .sys_rst_i, .addr_i, .wr_data_i, .wr_en_i,
    .rd_en_i, .rd_data_o, .tx_o, .tx_oe_o, .shared_oe_o, .irq_o);

// ---- tb/uart_control_config_test.sv ----
`timescale 1ns/1ps
`define check(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
    $display("[FAIL] %s exp %h got %h", nm, exp, got); end end

module uart_control_config_test;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wr_data_i = 8'h00;
    logic wr_en_i = 1'b0;
    logic rd_en_i = 1'b0;
    logic uart_clk_off_i = 1'b0;
    logic [7:0] rd_data_o, rem_got, v;
    logic tx_o, tx_oe_o, shared_o, shared_oe_o, irq_o, rem_do, rem_oe, tx_line, shared_line;
    int err_total = 0;
    int tests_run = 0;

    always #12.5 sys_clk_i = ~sys_clk_i;
    // Both pins idle high through a pull-up when released
    assign tx_line = tx_oe_o ? tx_o : 1'b1;
    assign shared_line = shared_oe_o ? shared_o : (rem_oe ? rem_do : 1'b1);

    uart_control_config i_dut (.sys_clk_i, .sys_rst_i, .addr_i, .wr_data_i, .wr_en_i, .rd_en_i, .rd_data_o,
        .uart_clk_off_i, .tx_o, .tx_oe_o, .shared_i(shared_line), .shared_o, .shared_oe_o, .irq_o);
    uart_remote_model i_rem (.sys_clk_i, .line_i(tx_line), .drive_o(rem_do), .oe_o(rem_oe), .got_o(rem_got));

    // ----------------------------------------
    // Register access
    // ----------------------------------------
    task automatic test_done();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_en_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_en_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        #1;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_en_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_en_i <= 1'b0;
        #1;
        d = rd_data_o;
    endtask : rd

    task automatic rc(input logic [2:0] a, input logic [7:0] exp, input string nm);
        rd(a, v);
        `check(nm, exp, v)
    endtask : rc

    task automatic wait_bit(input int b);
        for (int i = 0; i < 400; i++) begin
            rd(3'h3, v);
            if (v[b] === 1'b1)
                return;
        end
        err_total++;
        test_done();
    endtask : wait_bit

    initial begin
        repeat (16) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        rc(3'h0, 8'h00, "frame");
        rc(3'h1, 8'h00, "enable");
        rc(3'h3, 8'h0b, "status");
        rc(3'h6, 8'h00, "unmapped");
        `check("tx_oe", 1'b0, tx_oe_o)
        wr(3'h2, 8'hff);
        rc(3'h2, 8'h01, "wire");
        wr(3'h0, 8'h80);
        wr(3'h5, 8'h00);
        wr(3'h1, 8'ha0);
        `check("sw_oe", 1'b1, shared_oe_o)
        `check("sw_tx_oe", 1'b0, tx_oe_o)
        `check("sw_idle", 1'b1, shared_o)
        wr(3'h1, 8'he0);
        `check("sw_both_oe", 1'b0, shared_oe_o)
        wr(3'h2, 8'h00);
        `check("tx_oe_on", 1'b1, tx_oe_o)
        wr(3'h4, 8'ha5);
        wait_bit(1);
        `check("tx_byte", 8'ha5, rem_got)
        i_rem.send(8'h3c);
        wait_bit(2);
        rc(3'h4, 8'h3c, "rx_byte");
        wr(3'h1, 8'he4);
        `check("irq_off", 1'b0, irq_o)
        i_rem.send(8'h55);
        wait_bit(2);
        `check("irq_rx", 1'b1, irq_o)
        rc(3'h4, 8'h55, "rx_byte2");
        wr(3'h1, 8'he1);
        `check("irq_empty", 1'b1, irq_o)
        wr(3'h1, 8'he2);
        `check("irq_idle", 1'b1, irq_o)
        wr(3'h1, 8'he0);
        `check("irq_none", 1'b0, irq_o)
        wr(3'h1, 8'hf4);
        i_rem.send(8'h12);
        repeat (20) @(posedge sys_clk_i);
        rc(3'h3, 8'h0b, "addr_drop");
        `check("addr_irq0", 1'b0, irq_o)
        i_rem.send(8'h92);
        wait_bit(2);
        `check("addr_irq1", 1'b1, irq_o)
        rc(3'h4, 8'h92, "addr_byte");
        wr(3'h0, 8'hb0);
        wr(3'h4, 8'h05);
        wait_bit(1);
        `check("par_odd", 8'h85, rem_got)
        wr(3'h0, 8'h84);
        repeat (300) @(negedge sys_clk_i);
        `check("brk_low", 1'b0, tx_o)
        wr(3'h0, 8'h80);
        `check("brk_end", 1'b1, tx_o)
        wr(3'h4, 8'h5a);
        repeat (40) @(posedge sys_clk_i);
        wr(3'h0, 8'h00);
        rc(3'h3, 8'h0b, "off_status");
        rc(3'h1, 8'h34, "off_enable");
        `check("off_oe", 1'b0, tx_oe_o)
        wr(3'h0, 8'h80);
        rc(3'h1, 8'h34, "on_enable");
        wr(3'h1, 8'h40);
        `check("tx_oe_off", 1'b0, tx_oe_o)
        wr(3'h1, 8'h48);
        i_rem.send(8'h00);
        `check("no_wake", 1'b0, irq_o)
        uart_clk_off_i <= 1'b1;
        i_rem.send(8'h00);
        `check("wake", 1'b1, irq_o)
        test_done();
    end
endmodule : uart_control_config_test
